// *** core/mnf_memsys.sv ***
`timescale 1ns/10ps
module mnf_memsys
    import mnf_pkg::*;
#(
    parameter logic [23:0] ID_CODE  = 24'h5a0102, // arbitrary value
    parameter logic [7:0]  REV_CODE = 8'h01       // arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  reg_off,
    input  wire logic        reg_we,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata_ff,
    input  wire logic        ccp_unlock,
    input  wire logic        prog_mode,
    input  wire logic        prog_fuse_we,
    input  wire logic        prog_lock_we,
    input  wire logic [7:0]  prog_wdata,
    input  wire logic        nvm_done,
    input  wire logic        nvm_rd_valid,
    input  wire logic [23:0] nvm_rdata,
    output logic             nvm_start_ff,
    output logic             chip_erase_ff,
    output logic             user_erase_ff,
    output logic             nonvolatile_busy_ff,
    output logic      [23:0] nvm_address_ff,
    output logic      [6:0]  nvm_command_ff,
    output logic             jtag_disabled_ff,
    input  wire logic        io_wr_req,
    output logic             io_wr_ok_ff,
    output logic             io_direct_ok_ff,
    output logic             io_bit_ok_ff,
    input  wire logic [2:0]  m_req,
    input  wire logic [2:0]  m_burst,
    input  wire logic [2:0]  m_we,
    input  wire logic [23:0] m_addr [3],
    output logic      [2:0]  m_gnt_ff,
    output logic      [2:0]  m_done_ff
);
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // target bus of a data-space address
    function automatic logic [1:0] dec(input logic [23:0] a,
                                       input logic em);
        if (a > SRAM_END) dec = BUS_EXT;
        else if (a >= SRAM_BASE) dec = BUS_SRAM;
        else if (em && a >= EE_BASE) dec = BUS_EE;
        else dec = BUS_IO;
    endfunction : dec

    // cycles for one beat; cont marks a continuing burst
    function automatic logic [1:0] lat(input logic [1:0] b,
                                       input logic we,
                                       input logic cont);
        case (b)
            BUS_IO: lat = LAT_IO;
            BUS_EE: lat = we ? LAT_EE_WR :
                          (cont ? LAT_EE_BS : LAT_EE_RD);
            BUS_SRAM: lat = we ? LAT_SRAM_WR :
                            (cont ? LAT_SRAM_BS : LAT_SRAM_RD);
            default: lat = LAT_EXT;
        endcase
    endfunction : lat

    // cpu first, then dma read, then dma write
    function automatic logic [1:0] pick(input logic [2:0] v);
        if (v[0]) pick = 2'h0;
        else if (v[1]) pick = 2'h1;
        else if (v[2]) pick = 2'h2;
        else pick = NO_OWNER;
    endfunction : pick

    function automatic logic [2:0] oh(input logic [1:0] o);
        oh = (o == NO_OWNER) ? 3'h0 : 3'(3'h1 << o);
    endfunction : oh

    // -------------------------------------------------------------
    // controller state
    // -------------------------------------------------------------
    mnf_state_e  state_ff;           // operation sequencer
    logic [2:0]  ccp_cnt_ff;         // protection window left
    logic [23:0] nvm_data_ff;        // data bytes
    logic        eemap_ff;           // eeprom mapping enable
    logic [7:0]  lock_ff;            // lock bits, 1 = open
    logic [7:0]  fuse_ff;            // fuse byte copy
    logic        iolock_ff;          // critical i/o lock
    logic        ccp_open;           // window currently open
    logic        exec_wr;            // software sets execute
    logic        exec_ok;            // accepted launch
    logic        cmd_legal;          // command allowed now
    logic [2:0]  busy_oh  [4];       // owner per bus, next
    logic [2:0]  done_oh  [4];       // finishing owner per bus

    // every check runs on the one clock and rests during reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    assign ccp_open  = (ccp_cnt_ff != 3'h0);
    assign exec_wr   = reg_we && (reg_off == OFF_NVM_CONTROL_A)
                       && reg_wdata[EXEC_BIT];
    // external-only commands need the programmer in control
    assign cmd_legal = prog_mode || !nvm_command_ff[EXTCMD_BIT];
    assign exec_ok   = exec_wr && ccp_open && cmd_legal
                       && (state_ff == MNF_IDLE);

    // -------------------------------------------------------------
    // protection window
    // -------------------------------------------------------------
    // window counts down; a fresh unlock reloads it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ccp_cnt_ff <= 3'h0;
        end else if (ccp_unlock) begin
            ccp_cnt_ff <= CCP_WIN;
        end else if (ccp_open) begin
            ccp_cnt_ff <= ccp_cnt_ff - 3'h1;
        end
    end

    // -------------------------------------------------------------
    // address, data and command bytes
    // -------------------------------------------------------------
    // software writes bytes; a read result lands in data
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            nvm_address_ff <= 24'h000000;
            nvm_data_ff    <= 24'h000000;
            nvm_command_ff <= 7'h00;
        end else begin
            if (reg_we && reg_off == OFF_ADDR_L)
                nvm_address_ff[7:0] <= reg_wdata;
            if (reg_we && reg_off == OFF_ADDR_M)
                nvm_address_ff[15:8] <= reg_wdata;
            if (reg_we && reg_off == OFF_ADDR_H)
                nvm_address_ff[23:16] <= reg_wdata;
            if (nvm_rd_valid) begin
                nvm_data_ff <= nvm_rdata;
            end else begin
                if (reg_we && reg_off == OFF_DATA_L)
                    nvm_data_ff[7:0] <= reg_wdata;
                if (reg_we && reg_off == OFF_DATA_M)
                    nvm_data_ff[15:8] <= reg_wdata;
                if (reg_we && reg_off == OFF_DATA_H)
                    nvm_data_ff[23:16] <= reg_wdata;
            end
            if (reg_we && reg_off == OFF_CMD)
                nvm_command_ff <= reg_wdata[6:0];
        end
    end

    AST_CMD_TOP: assert property (
        reg_we && reg_off == OFF_CMD
        |=> nvm_command_ff == $past(reg_wdata[6:0]))
        else $error("command byte not stored");

    // -------------------------------------------------------------
    // operation sequencer
    // -------------------------------------------------------------
    // busy is set on launch and drops only with nvm_done
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff            <= MNF_IDLE;
            nvm_start_ff        <= 1'b0;
            user_erase_ff       <= 1'b0;
            chip_erase_ff       <= 1'b0;
            nonvolatile_busy_ff <= 1'b0;
        end else begin
            nvm_start_ff  <= 1'b0;
            user_erase_ff <= 1'b0;
            unique case (state_ff)
                MNF_IDLE: begin
                    if (exec_ok) begin
                        nvm_start_ff        <= 1'b1;
                        nonvolatile_busy_ff <= 1'b1;
                        user_erase_ff <=
                            (nvm_command_ff == CMD_USER_ERASE);
                        if (nvm_command_ff == CMD_CHIP_ERASE) begin
                            chip_erase_ff <= 1'b1;
                            state_ff      <= MNF_ERASE;
                        end else begin
                            state_ff <= MNF_RUN;
                        end
                    end
                end
                MNF_RUN: begin
                    if (nvm_done) begin
                        nonvolatile_busy_ff <= 1'b0;
                        state_ff            <= MNF_IDLE;
                    end
                end
                MNF_ERASE: begin
                    // flash array done; locks follow below
                    if (nvm_done) begin
                        chip_erase_ff       <= 1'b0;
                        nonvolatile_busy_ff <= 1'b0;
                        state_ff            <= MNF_IDLE;
                    end
                end
            endcase
        end
    end

    // launch steps: accepted write, then start with busy
    sequence s_launch;
        exec_wr && ccp_open && cmd_legal && state_ff == MNF_IDLE;
    endsequence
    sequence s_started;
        nvm_start_ff && nonvolatile_busy_ff;
    endsequence

    AST_EXEC_STARTS: assert property (
        s_launch |=> s_started)
        else $error("protected execute did not launch");
    AST_EXEC_GUARDED: assert property (
        exec_wr && !ccp_open |=> !nvm_start_ff)
        else $error("unprotected execute launched");
    AST_BUSY_HOLDS: assert property (
        nonvolatile_busy_ff && !nvm_done |=> nonvolatile_busy_ff)
        else $error("busy dropped early");
    AST_BUSY_ENDS: assert property (
        nonvolatile_busy_ff && nvm_done |=> !nonvolatile_busy_ff)
        else $error("busy not cleared at finish");
    AST_USER_ROW: assert property (
        chip_erase_ff |-> !user_erase_ff)
        else $error("user row erased by chip erase");

    // -------------------------------------------------------------
    // lock bits and fuses
    // -------------------------------------------------------------
    // writes may only program lock bits (clear to zero); chip erase sets all back to one
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_ff <= LOCK_RST;
        end else if (state_ff == MNF_ERASE && nvm_done) begin
            lock_ff <= LOCK_RST;
        end else if (prog_lock_we) begin
            lock_ff <= lock_ff & prog_wdata;
        end else if (reg_we && reg_off == OFF_LOCK) begin
            lock_ff <= lock_ff & reg_wdata;
        end
    end

    AST_LOCK_STRICT: assert property (
        !(state_ff == MNF_ERASE && nvm_done)
        |=> (lock_ff & ~$past(lock_ff)) == 8'h00)
        else $error("lock bit loosened");
    AST_LOCK_ERASE: assert property (
        state_ff == MNF_ERASE && nvm_done |=> lock_ff == LOCK_RST)
        else $error("locks not cleared after erase");

    // software has no write path to the fuse copy
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_ff <= FUSE_RST;
        end else if (prog_fuse_we) begin
            fuse_ff <= prog_wdata;
        end
    end

    AST_FUSE_SW: assert property (
        !prog_fuse_we |=> $stable(fuse_ff))
        else $error("fuse changed without programmer");

    // -------------------------------------------------------------
    // control bits: mapping, jtag, i/o lock
    // -------------------------------------------------------------
    // jtag disable survives until reset or software re-enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            eemap_ff         <= 1'b0;
            jtag_disabled_ff <= 1'b0;
            iolock_ff        <= 1'b0;
        end else begin
            if (reg_we && reg_off == OFF_CTRLB)
                eemap_ff <= reg_wdata[EEMAP_BIT];
            if (reg_we && reg_off == OFF_JTAG)
                jtag_disabled_ff <= reg_wdata[0];
            if (reg_we && reg_off == OFF_IOLOCK && ccp_open)
                iolock_ff <= reg_wdata[0];
        end
    end

    // gated write strobe and i/o instruction reach
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            io_wr_ok_ff     <= 1'b0;
            io_direct_ok_ff <= 1'b0;
            io_bit_ok_ff    <= 1'b0;
        end else begin
            io_wr_ok_ff     <= io_wr_req && !iolock_ff;
            io_direct_ok_ff <= (m_addr[0][23:8] == 16'h0000)
                               && (m_addr[0][7:0] <= IO_DIRECT_END);
            io_bit_ok_ff    <= (m_addr[0][23:8] == 16'h0000)
                               && (m_addr[0][7:0] <= IO_BIT_END);
        end
    end

    AST_IO_LOCK: assert property (
        iolock_ff && io_wr_req |=> !io_wr_ok_ff)
        else $error("locked i/o write passed");

    // -------------------------------------------------------------
    // register read port
    // -------------------------------------------------------------
    // data shows one edge after the offset; strobes read zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            case (reg_off)
                OFF_ADDR_L: reg_rdata_ff <= nvm_address_ff[7:0];
                OFF_ADDR_M: reg_rdata_ff <= nvm_address_ff[15:8];
                OFF_ADDR_H: reg_rdata_ff <= nvm_address_ff[23:16];
                OFF_DATA_L: reg_rdata_ff <= nvm_data_ff[7:0];
                OFF_DATA_M: reg_rdata_ff <= nvm_data_ff[15:8];
                OFF_DATA_H: reg_rdata_ff <= nvm_data_ff[23:16];
                OFF_CMD:    reg_rdata_ff <= {1'b0, nvm_command_ff};
                OFF_CTRLB:  reg_rdata_ff <= {4'h0, eemap_ff, 3'h0};
                OFF_STATUS:
                    reg_rdata_ff <= {nonvolatile_busy_ff, 7'h00};
                OFF_LOCK:   reg_rdata_ff <= lock_ff;
                OFF_FUSE:   reg_rdata_ff <= fuse_ff;
                OFF_JTAG:   reg_rdata_ff <= {7'h00, jtag_disabled_ff};
                OFF_IOLOCK: reg_rdata_ff <= {7'h00, iolock_ff};
                OFF_ID0:    reg_rdata_ff <= ID_CODE[7:0];
                OFF_ID1:    reg_rdata_ff <= ID_CODE[15:8];
                OFF_ID2:    reg_rdata_ff <= ID_CODE[23:16];
                OFF_REV:    reg_rdata_ff <= REV_CODE;
                default:    reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------
    // per-bus arbiters
    // -------------------------------------------------------------
    // one arbiter per bus
    for (genvar gb = 0; gb < 4; gb++) begin : g_bus
        logic [2:0] want;     // masters aiming here
        logic [1:0] own_ff;   // current owner
        logic [1:0] cnt_ff;   // cycles left in beat
        logic       bst_ff;   // owner is bursting
        logic [1:0] nxt_own;
        logic [1:0] nxt_cnt;
        logic       nxt_bst;
        logic [1:0] w;
        logic       cont;

        always_comb begin
            for (int m = 0; m < 3; m++) begin
                want[m] = m_req[m] &&
                          (dec(m_addr[m], eemap_ff) == 2'(gb));
            end
        end

        // new winner only once the running beat ends
        always_comb begin
            nxt_own = own_ff;
            nxt_cnt = cnt_ff;
            nxt_bst = bst_ff;
            w       = NO_OWNER;
            cont    = 1'b0;
            if (cnt_ff > 2'h1) begin
                nxt_cnt = cnt_ff - 2'h1;
            end else begin
                if (bst_ff && own_ff != NO_OWNER
                    && (want & m_burst & oh(own_ff)) != 3'h0) begin
                    cont = 1'b1;
                    w    = own_ff;
                    if (own_ff == 2'h1 && want[2] && m_burst[2])
                        w = 2'h2;
                    else if (own_ff == 2'h2 && want[1] && m_burst[1])
                        w = 2'h1;
                end else if ((want & m_burst) != 3'h0) begin
                    w = pick(want & m_burst);
                end else begin
                    w = pick(want);
                end
                nxt_own = w;
                nxt_bst = (w != NO_OWNER) && m_burst[w];
                nxt_cnt = (w == NO_OWNER) ? 2'h0 :
                          lat(2'(gb), m_we[w], cont);
            end
        end

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                own_ff <= NO_OWNER;
                cnt_ff <= 2'h0;
                bst_ff <= 1'b0;
            end else begin
                own_ff <= nxt_own;
                cnt_ff <= nxt_cnt;
                bst_ff <= nxt_bst;
            end
        end

        assign busy_oh[gb] = oh(nxt_own);
        assign done_oh[gb] = (cnt_ff == 2'h1) ? oh(own_ff) : 3'h0;
    end

    // grant and completion summed over all buses
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            m_gnt_ff  <= 3'h0;
            m_done_ff <= 3'h0;
        end else begin
            m_gnt_ff  <= busy_oh[0] | busy_oh[1] | busy_oh[2]
                         | busy_oh[3];
            m_done_ff <= done_oh[0] | done_oh[1] | done_oh[2]
                         | done_oh[3];
        end
    end

endmodule : mnf_memsys

// *** core/mnf_pkg.sv ***
// How it works
// - chip erase spares user row; dedicated erase
// - fuses written only by external programmer
// - lock bits only move toward stricter
// - chip erase clears locks after flash
// - unprogrammed bit reads one, programmed zero
// - external space from SRAM end upward
// - internal SRAM starts at fixed address
// - EEPROM mapped at fixed base when enabled
// - direct and bit I/O address ranges
// - separate bus per memory set
// - ongoing, burst, burst request, single order
// - DMA read and write bursts alternate
// - CPU wins within equal class
// - I/O and SRAM access latencies
// - EEPROM load and read latencies
// - read-only ID bytes and revision
// - software boundary-scan disable until reset or software re-enable
// - I/O lock blocks writes; lock protected
// - three bytes form 24-bit address
// - three bytes form 24-bit data
// - 7-bit command, top bit zero
// - protected execute bit launches command
// - busy flag spans whole operation
package mnf_pkg;
    // -------------------------------------------------------------
    // register offsets inside the controller block
    // -------------------------------------------------------------
    localparam logic [4:0] OFF_ADDR_L = 5'h00;
    localparam logic [4:0] OFF_ADDR_M = 5'h01;
    localparam logic [4:0] OFF_ADDR_H = 5'h02;
    localparam logic [4:0] OFF_DATA_L = 5'h04;
    localparam logic [4:0] OFF_DATA_M = 5'h05;
    localparam logic [4:0] OFF_DATA_H = 5'h06;
    localparam logic [4:0] OFF_CMD    = 5'h0a;
    localparam logic [4:0] OFF_NVM_CONTROL_A  = 5'h0b;
    localparam logic [4:0] OFF_CTRLB  = 5'h0c;
    localparam logic [4:0] OFF_STATUS = 5'h0f;
    localparam logic [4:0] OFF_LOCK   = 5'h10;
    localparam logic [4:0] OFF_FUSE   = 5'h11;
    localparam logic [4:0] OFF_JTAG   = 5'h12;
    localparam logic [4:0] OFF_IOLOCK = 5'h13;
    localparam logic [4:0] OFF_ID0    = 5'h14;
    localparam logic [4:0] OFF_ID1    = 5'h15;
    localparam logic [4:0] OFF_ID2    = 5'h16;
    localparam logic [4:0] OFF_REV    = 5'h17;
    // field positions
    localparam int EXEC_BIT   = 0;
    localparam int EEMAP_BIT  = 3;
    localparam int EXTCMD_BIT = 6;
    localparam int BUSY_BIT   = 7;
    // -------------------------------------------------------------
    // data map and buses
    // -------------------------------------------------------------
    localparam logic [23:0] EE_BASE   = 24'h001000;
    localparam logic [23:0] SRAM_BASE = 24'h002000;
    localparam logic [23:0] SRAM_END  = 24'h003fff;
    localparam logic [7:0]  IO_DIRECT_END = 8'h3f;
    localparam logic [7:0]  IO_BIT_END    = 8'h1f;
    localparam logic [1:0] BUS_IO   = 2'h0;
    localparam logic [1:0] BUS_EE   = 2'h1;
    localparam logic [1:0] BUS_SRAM = 2'h2;
    localparam logic [1:0] BUS_EXT  = 2'h3;
    localparam logic [1:0] NO_OWNER = 2'h3;
    // access cycles per beat
    localparam logic [1:0] LAT_IO      = 2'h1;
    localparam logic [1:0] LAT_SRAM_WR = 2'h1;
    localparam logic [1:0] LAT_SRAM_RD = 2'h2;
    localparam logic [1:0] LAT_SRAM_BS = 2'h1;
    localparam logic [1:0] LAT_EE_WR   = 2'h1;
    localparam logic [1:0] LAT_EE_RD   = 2'h3;
    localparam logic [1:0] LAT_EE_BS   = 2'h2;
    localparam logic [1:0] LAT_EXT     = 2'h3;
    // -------------------------------------------------------------
    // controller constants
    // -------------------------------------------------------------
    localparam logic [2:0] CCP_WIN        = 3'h4;
    localparam logic [6:0] CMD_CHIP_ERASE = 7'h40;
    localparam logic [6:0] CMD_USER_ERASE = 7'h18;
    localparam logic [7:0] LOCK_RST       = 8'hff;
    localparam logic [7:0] FUSE_RST       = 8'hff;
    typedef enum logic [2:0] {
        MNF_IDLE  = 3'b001,
        MNF_RUN   = 3'b010,
        MNF_ERASE = 3'b100
    } mnf_state_e;
endpackage : mnf_pkg

// *** sim/mnf_nvm_model.sv ***
`timescale 1ns/10ps
module mnf_nvm_model #(parameter int DLY = 6) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    output logic             done,
    output logic      [23:0] rdata);
    int cnt; // cycles until the array answers, long enough to probe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) cnt <= 0;
        else if (start) cnt <= DLY;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign done = (cnt == 1);
    // idle data lines show the inverse, never a stale copy
    assign rdata = done ? 24'ha5c33c : 24'h5a3cc3;
endmodule : mnf_nvm_model

// *** sim/tb_mnf_memsys.sv ***
`timescale 1ns/10ps
module tb_mnf_memsys import mnf_pkg::*;;
    logic sys_clk = 0, reset_n = 0, reg_we = 0, ccp_unlock = 0;
    logic prog_mode = 0, prog_fuse_we = 0, prog_lock_we = 0, io_direct_ok_ff;
    logic io_wr_req = 1, nvm_done, nvm_start_ff, chip_erase_ff, io_wr_ok_ff;
    logic user_erase_ff, nonvolatile_busy_ff, jtag_disabled_ff, io_bit_ok_ff;
    logic [2:0] m_req = 0, m_burst = 0, m_we = 0, m_gnt_ff, m_done_ff;
    logic [4:0] reg_off = 0;
    logic [6:0] nvm_command_ff;
    logic [7:0] reg_wdata = 0, prog_wdata = 0, reg_rdata_ff;
    logic [23:0] m_addr [3] = '{0, 0, 0}, nvm_rdata, nvm_address_ff;
    int num_errors = 0, checks_done = 0, n;
    localparam logic [23:0] ID_T  = 24'h3c2a19; // arbitrary value
    localparam logic [7:0]  REV_T = 8'h07;      // arbitrary value
    mnf_memsys #(.ID_CODE(ID_T), .REV_CODE(REV_T)) u_dut (.sys_clk,
        .reset_n, .reg_off, .reg_we, .reg_wdata, .reg_rdata_ff,
        .ccp_unlock, .prog_mode, .prog_fuse_we, .prog_lock_we, .prog_wdata,
        .nvm_done, .nvm_rd_valid(nvm_done), .nvm_rdata, .nvm_start_ff,
        .chip_erase_ff, .user_erase_ff, .nonvolatile_busy_ff,
        .nvm_address_ff, .nvm_command_ff, .jtag_disabled_ff, .io_wr_req,
        .io_wr_ok_ff, .io_direct_ok_ff, .io_bit_ok_ff, .m_req, .m_burst,
        .m_we, .m_addr, .m_gnt_ff, .m_done_ff);
    mnf_nvm_model u_nvm (.sys_clk, .reset_n, .start(nvm_start_ff),
        .done(nvm_done), .rdata(nvm_rdata));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [23:0] got, exp);
        checks_done++;
        if (got !== exp) num_errors++;
        if (got !== exp) $display("[ERR] %s exp %h got %h", nm, exp, got);
    endtask : chk
    // optional unlock pulse first, so the write lands inside the window
    task automatic wr(input logic [4:0] o, input logic [7:0] d, logic c);
        @(posedge sys_clk) #1 ccp_unlock = c;
        @(posedge sys_clk) #1 ccp_unlock = 0;
        reg_off = o;
        reg_wdata = d;
        reg_we = 1;
        @(posedge sys_clk) #1 reg_we = 0;
    endtask : wr
    task automatic rdc(input logic [4:0] o, input logic [7:0] e);
        @(posedge sys_clk) #1 reg_off = o;
        @(posedge sys_clk) #1 chk($sformatf("off %h", o), reg_rdata_ff, e);
    endtask : rdc
    task automatic wait_idle;
        for (n = 0; n < 40 && nonvolatile_busy_ff !== 1'b0; n++)
            @(posedge sys_clk) #1;
        chk("busy_end", nonvolatile_busy_ff, 0);
    endtask : wait_idle
    // cpu request held until its beat completes; the arbiter re-grants
    // on the done edge, so that extra beat drains before the next call
    task automatic acc(input logic [23:0] a, input int e);
        m_addr[0] = a;
        m_req = 3'b001;
        for (n = 1; n < 20; n++)
            @(posedge sys_clk) #1 if (m_done_ff[0] === 1'b1) break;
        m_req = 0;
        chk("latency", n, e);
        repeat (4) @(posedge sys_clk) #1;
    endtask : acc
    task automatic tally_and_finish(input int extra);
        num_errors += extra;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    initial #100000 tally_and_finish(1);
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1;
        wr(OFF_FUSE, 8'h00, 0);
        rdc(OFF_FUSE, 8'hff);
        wr(OFF_LOCK, 8'hf0, 0);
        wr(OFF_LOCK, 8'hff, 0);
        rdc(OFF_LOCK, 8'hf0);
        prog_wdata = 8'hcc;
        prog_fuse_we = 1;
        prog_lock_we = 1;
        @(posedge sys_clk) #1 prog_fuse_we = 0;
        prog_lock_we = 0;
        rdc(OFF_FUSE, 8'hcc);
        rdc(OFF_LOCK, 8'hc0);
        wr(OFF_IOLOCK, 8'h01, 0);
        wr(OFF_ADDR_H, 8'h56, 0);
        chk("address", nvm_address_ff, 24'h560000);
        chk("io_write", io_wr_ok_ff, 1);
        wr(OFF_IOLOCK, 8'h01, 1);
        @(posedge sys_clk) #1 chk("io_locked", io_wr_ok_ff, 0);
        wr(OFF_JTAG, 8'h01, 0);
        chk("jtag_off", jtag_disabled_ff, 1);
        wr(OFF_JTAG, 8'h00, 0);
        chk("jtag_on", jtag_disabled_ff, 0);
        wr(OFF_ID0, 8'h00, 0);
        rdc(OFF_ID0, ID_T[7:0]);
        rdc(OFF_ID1, ID_T[15:8]);
        rdc(OFF_ID2, ID_T[23:16]);
        rdc(OFF_REV, REV_T);
        $display("register test done");
        wr(OFF_CMD, 8'h02, 0);
        chk("command", nvm_command_ff, 7'h02);
        wr(OFF_NVM_CONTROL_A, 8'h01, 0);
        chk("no_key", nvm_start_ff, 0);
        wr(OFF_NVM_CONTROL_A, 8'h01, 1);
        chk("start", nvm_start_ff, 1);
        chk("busy", nonvolatile_busy_ff, 1);
        wait_idle();
        rdc(OFF_DATA_H, 8'ha5);
        wr(OFF_CMD, 8'h40, 0);
        wr(OFF_NVM_CONTROL_A, 8'h01, 1);
        chk("no_prog", nvm_start_ff, 0);
        prog_mode = 1;
        wr(OFF_NVM_CONTROL_A, 8'h01, 1);
        chk("erase", chip_erase_ff, 1);
        chk("user_row", user_erase_ff, 0);
        rdc(OFF_LOCK, 8'hc0);
        wait_idle();
        rdc(OFF_LOCK, 8'hff);
        wr(OFF_CMD, {1'b0, CMD_USER_ERASE}, 0);
        wr(OFF_NVM_CONTROL_A, 8'h01, 1);
        chk("user_erase", user_erase_ff, 1);
        wait_idle();
        $display("command test done");
        acc(24'h002000, LAT_SRAM_RD + 1);
        acc(24'h00003f, LAT_IO + 1);
        chk("io_direct", io_direct_ok_ff, 1);
        chk("io_bit", io_bit_ok_ff, 0);
        acc(24'h001000, LAT_IO + 1);
        wr(OFF_CTRLB, 8'h08, 0);
        acc(24'h001000, LAT_EE_RD + 1);
        acc(24'h004000, LAT_EXT + 1);
        m_addr = '{24'h002000, 24'h002010, 24'h002020};
        m_burst = 3'b110;
        m_we = 3'b100;
        m_req = 3'b111;
        @(posedge sys_clk) #1 chk("burst_first", m_gnt_ff, 3'b010);
        repeat (2) @(posedge sys_clk) #1;
        chk("alt_wr", m_gnt_ff, 3'b100);
        @(posedge sys_clk) #1 chk("alt_rd", m_gnt_ff, 3'b010);
        m_req = 0;
        repeat (4) @(posedge sys_clk) #1;
        m_burst = 3'b011;
        m_req = 3'b011;
        @(posedge sys_clk) #1 chk("cpu_first", m_gnt_ff, 3'b001);
        m_req = 0;
        repeat (4) @(posedge sys_clk) #1;
        m_addr[0] = 24'h000010;
        m_req = 3'b011;
        @(posedge sys_clk) #1 chk("two_buses", m_gnt_ff, 3'b011);
        m_req = 0;
        $display("bus test done");
        tally_and_finish(0);
    end
endmodule : tb_mnf_memsys
